// ### audio_dp_pkg.sv
// Shared constants and carriers of the fixed-point audio datapath.
// Assumes one system clock; coefficient words come from a serial control decoder.
package audio_dp_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int DATA_W  = 48;
    localparam int COEF_W  = 28;
    localparam int PROD_W  = DATA_W + COEF_W;
    localparam int FRAC_W  = 23;
    localparam int WORD_W  = 32;
    localparam int HI_W    = DATA_W - WORD_W;
    localparam int CHAN_W  = 3;
    localparam int ADDR_W  = 5;
    localparam int TERM_W  = 2;

    // ****************************************
    // Saturation limits and reset values
    // ****************************************
    localparam logic [DATA_W-1:0] SAT_MAX   = 48'h7fff_ffff_ffff;
    localparam logic [DATA_W-1:0] SAT_MIN   = 48'h8000_0000_0000;
    localparam logic [DATA_W-1:0] UNITY_48  = 48'h0000_0080_0000;
    localparam logic [DATA_W-1:0] ZERO_48   = 48'h0000_0000_0000;
    localparam logic [PROD_W-1:0] ZERO_ACC  = '0;

    // ****************************************
    // Coefficient store layout
    // ****************************************
    localparam int COEF_DEPTH = 32;
    localparam logic [ADDR_W-1:0] GAIN_BASE   = 5'h00;
    localparam logic [ADDR_W-1:0] LEVEL_BASE  = 5'h08;
    localparam logic [ADDR_W-1:0] MASTER_ADDR = 5'h10;
    localparam logic [ADDR_W-1:0] MIX_BASE    = 5'h18;

    // ****************************************
    // Channel plan
    // ****************************************
    localparam logic [CHAN_W-1:0] PASS_LO    = 3'h2;
    localparam logic [CHAN_W-1:0] PASS_HI    = 3'h6;
    localparam logic [CHAN_W-1:0] TRIPLE_LO  = 3'h6;
    localparam logic [TERM_W-1:0] TERMS_TWO  = 2'h2;
    localparam logic [TERM_W-1:0] TERMS_THREE = 2'h3;

    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_GAIN   = 6'b000010,
        ST_LEVEL  = 6'b000100,
        ST_MASTER = 6'b001000,
        ST_EMIT   = 6'b010000,
        ST_MIX    = 6'b100000
    } seq_state_type;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic              mix;
        logic [CHAN_W-1:0] chan;
        logic [DATA_W-1:0] data;
    } sample_in_type;

    typedef struct packed {
        logic [CHAN_W-1:0] chan;
        logic [DATA_W-1:0] data;
    } sample_out_type;

    typedef struct packed {
        logic              wide;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] word;
    } coef_word_type;

endpackage

// ### fixed_gain_mult.sv
// Signed sample by signed coefficient multiplier with full and truncated product.
// Purely combinational; the caller registers the result.
`timescale 1ns/100ps
`default_nettype none

module fixed_gain_mult #(
    parameter int A_W    = 48,
    parameter int B_W    = 28,
    parameter int FRAC_W = 23
) (
    // Operands
    input  wire logic signed [A_W-1:0]     sample,
    input  wire logic signed [B_W-1:0]     coef,
    // Results
    output logic signed [A_W+B_W-1:0]      product,
    output logic signed [A_W-1:0]          trunc
);

    assign product = sample * coef;
    // Drop the extra fraction bits and the overflow bits above the 25.23 range
    assign trunc   = product[A_W+FRAC_W-1:FRAC_W];

endmodule

`default_nettype wire

// ### audio_fixed_point_datapath.sv
// Fixed-point arithmetic core of the eight-channel audio_processing_core.
// Assumes synchronous sample and coefficient sources and one clock, ref_clk.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Samples are signed 48-bit two's complement, top bit is sign.
// - Gain step multiplies a signed 48-bit sample by a signed 28-bit coefficient.
// - Full 76-bit product is formed, then truncated to signed 48 bits.
// - Level offset step adds a signed 48-bit offset to the sample.
// - Positive addition overflow clamps to the largest positive value.
// - Negative addition overflow clamps to the most negative value.
// - Gain coefficients are 5.23 fixed point, 28 bits.
// - Gain coefficients are two's complement signed.
// - Gain coefficient sits in word bits 27:0, top nibble zero.
// - Level and threshold coefficients are 25.23 fixed point, 48 bits.
// - Mixer products accumulate in a 76-bit accumulator without clipping.
// - Processing sequence is fixed; only coefficients are programmable.
// - At high sample rates channels 3 to 7 get master volume only.
// - Output mixer sums two terms for channels 1-6, three for 7-8.
module audio_fixed_point_datapath
    import audio_dp_pkg::*;
#(
    parameter int DEPTH = COEF_DEPTH
) (
    // Clock, reset, enable
    input  wire logic           ref_clk,
    input  wire logic           rst,
    input  wire logic           clk_en,
    // Mode
    input  wire logic           high_rate,
    // Sample input stream
    input  wire logic           in_valid,
    input  wire sample_in_type  in_sample,
    output logic                in_ready,
    // Sample output stream
    output logic                out_valid,
    output var sample_out_type  out_sample,
    input  wire logic           out_ready,
    // Coefficient words
    input  wire logic           coef_valid,
    input  wire coef_word_type  coef_in,
    output logic                coef_pending
);

    // ****************************************
    // Declarations
    // ****************************************
    seq_state_type              state_reg;
    logic        [DATA_W-1:0]   coef_mem [DEPTH];
    logic        [HI_W-1:0]     hi_reg;
    logic                       hi_valid_reg;
    logic        [DATA_W-1:0]   work_reg;
    logic        [CHAN_W-1:0]   chan_reg;
    logic        [PROD_W-1:0]   acc_reg;
    logic        [TERM_W-1:0]   term_reg;
    logic                       in_ready_reg;
    sample_out_type             out_reg;
    logic                       out_valid_reg;
    sample_out_type             spare_reg;
    logic                       spare_valid_reg;
    logic        [ADDR_W-1:0]   coef_sel;
    logic signed [COEF_W-1:0]   mult_coef;
    logic signed [PROD_W-1:0]   mult_prod;
    logic signed [DATA_W-1:0]   mult_trunc;
    logic        [PROD_W-1:0]   acc_next;
    logic        [DATA_W:0]     sum_wide;
    logic        [DATA_W-1:0]   sum_sat;
    logic        [TERM_W-1:0]   term_last;
    logic                       take;
    logic                       pass_chan;
    logic                       push;
    logic                       pop;

    assign in_ready     = in_ready_reg;
    assign out_valid    = out_valid_reg;
    assign out_sample   = out_reg;
    assign coef_pending = hi_valid_reg;

    // ****************************************
    // Coefficient loading
    // ****************************************
    // High word of a two-word level coefficient
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hi_reg       <= '0;
            hi_valid_reg <= 1'b0;
        end else if (clk_en && coef_valid && coef_in.wide) begin
            if (!hi_valid_reg) begin
                hi_reg       <= coef_in.word[HI_W-1:0];
                hi_valid_reg <= 1'b1;
            end else begin
                hi_valid_reg <= 1'b0;
            end
        end
    end

    // Store: gains at unity, levels at zero after reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                coef_mem[i] <= (i < int'(LEVEL_BASE) || i >= int'(MASTER_ADDR)) ? UNITY_48 : ZERO_48;
            end
        end else if (clk_en && coef_valid) begin
            if (!coef_in.wide) begin
                // Sign-extend 5.23 field, top nibble ignored
                coef_mem[coef_in.addr] <= {{(DATA_W-COEF_W){coef_in.word[COEF_W-1]}},
                                           coef_in.word[COEF_W-1:0]};
            end else if (hi_valid_reg) begin
                coef_mem[coef_in.addr] <= {hi_reg, coef_in.word};
            end
        end
    end

    // ****************************************
    // Arithmetic
    // ****************************************
    always_comb begin
        case (state_reg)
            ST_GAIN:   coef_sel = GAIN_BASE + ADDR_W'(chan_reg);
            ST_MIX:    coef_sel = MIX_BASE + ADDR_W'(term_reg);
            default:   coef_sel = MASTER_ADDR;
        endcase
    end

    // 5.23 coefficient: integer value scaled by two to minus 23
    assign mult_coef = coef_mem[coef_sel][COEF_W-1:0];

    fixed_gain_mult #(
        .A_W    (DATA_W),
        .B_W    (COEF_W),
        .FRAC_W (FRAC_W)
    ) u_mult (
        .sample  (work_reg),
        .coef    (mult_coef),
        .product (mult_prod),
        .trunc   (mult_trunc)
    );

    // Level offset with saturation on either overflow
    assign sum_wide = {work_reg[DATA_W-1], work_reg}
                    + {coef_mem[LEVEL_BASE + ADDR_W'(chan_reg)][DATA_W-1],
                       coef_mem[LEVEL_BASE + ADDR_W'(chan_reg)]};

    always_comb begin
        case (sum_wide[DATA_W:DATA_W-1])
            2'b01:   sum_sat = SAT_MAX;
            2'b10:   sum_sat = SAT_MIN;
            default: sum_sat = sum_wide[DATA_W-1:0];
        endcase
    end

    // Full-width accumulation of mixer terms
    assign acc_next  = acc_reg + PROD_W'(mult_prod);
    assign term_last = (chan_reg >= TRIPLE_LO) ? (TERMS_THREE - 2'h1) : (TERMS_TWO - 2'h1);

    // ****************************************
    // Sequencer
    // ****************************************
    assign take      = in_valid && in_ready_reg;
    assign pass_chan = high_rate && in_sample.chan >= PASS_LO && in_sample.chan <= PASS_HI;
    assign push      = (state_reg == ST_EMIT) && !spare_valid_reg;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg    <= ST_IDLE;
            in_ready_reg <= 1'b1;
        end else if (clk_en) begin
            case (state_reg)
                ST_IDLE: begin
                    if (take) begin
                        in_ready_reg <= 1'b0;
                        if (in_sample.mix) begin
                            state_reg <= ST_MIX;
                        end else if (pass_chan) begin
                            state_reg <= ST_MASTER;
                        end else begin
                            state_reg <= ST_GAIN;
                        end
                    end
                end
                ST_GAIN:   state_reg <= ST_LEVEL;
                ST_LEVEL:  state_reg <= ST_MASTER;
                ST_MASTER: state_reg <= ST_EMIT;
                ST_MIX: begin
                    if (term_reg == term_last) begin
                        state_reg <= ST_EMIT;
                    end else begin
                        state_reg    <= ST_IDLE;
                        in_ready_reg <= 1'b1;
                    end
                end
                ST_EMIT: begin
                    if (push) begin
                        state_reg    <= ST_IDLE;
                        in_ready_reg <= 1'b1;
                    end
                end
                default: begin
                    state_reg    <= ST_IDLE;
                    in_ready_reg <= 1'b1;
                end
            endcase
        end
    end

    // Working sample
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            work_reg <= ZERO_48;
            chan_reg <= '0;
        end else if (clk_en) begin
            case (state_reg)
                ST_IDLE: begin
                    if (take) begin
                        work_reg <= in_sample.data;
                        chan_reg <= in_sample.chan;
                    end
                end
                ST_GAIN:   work_reg <= mult_trunc;
                ST_LEVEL:  work_reg <= sum_sat;
                ST_MASTER: work_reg <= mult_trunc;
                ST_MIX: begin
                    if (term_reg == term_last) begin
                        work_reg <= acc_next[DATA_W+FRAC_W-1:FRAC_W];
                    end
                end
                default: work_reg <= work_reg;
            endcase
        end
    end

    // Mixer accumulator and term count
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_reg  <= ZERO_ACC;
            term_reg <= '0;
        end else if (clk_en && state_reg == ST_MIX) begin
            if (term_reg == term_last) begin
                acc_reg  <= ZERO_ACC;
                term_reg <= '0;
            end else begin
                acc_reg  <= acc_next;
                term_reg <= term_reg + 2'h1;
            end
        end
    end

    // ****************************************
    // Two-entry output buffer
    // ****************************************
    assign pop = out_valid_reg && out_ready;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            out_reg         <= '0;
            out_valid_reg   <= 1'b0;
            spare_reg       <= '0;
            spare_valid_reg <= 1'b0;
        end else if (clk_en) begin
            if (!out_valid_reg || pop) begin
                if (spare_valid_reg) begin
                    out_reg         <= spare_reg;
                    spare_valid_reg <= 1'b0;
                end else begin
                    out_valid_reg <= push;
                    out_reg       <= '{chan: chan_reg, data: work_reg};
                end
            end else if (push) begin
                spare_reg       <= '{chan: chan_reg, data: work_reg};
                spare_valid_reg <= 1'b1;
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    a_sat_positive: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && state_reg == ST_LEVEL && sum_wide[DATA_W:DATA_W-1] == 2'b01 |=> work_reg == SAT_MAX)
        else $error("positive overflow not clamped");

    a_sat_negative: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && state_reg == ST_LEVEL && sum_wide[DATA_W:DATA_W-1] == 2'b10 |=> work_reg == SAT_MIN)
        else $error("negative overflow not clamped");

    a_gain_trunc: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && state_reg == ST_GAIN |=> work_reg == $past(mult_prod[70:23]))
        else $error("gain product not truncated to 25.23");

    a_pass_route: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && take && !in_sample.mix && pass_chan |=> state_reg == ST_MASTER)
        else $error("pass-through channel took full chain");

    a_full_chain: assert property (@(posedge ref_clk) disable iff (rst || !clk_en)
        clk_en && take && !in_sample.mix && !pass_chan |=> state_reg == ST_GAIN
        ##1 state_reg == ST_LEVEL ##1 state_reg == ST_MASTER ##1 state_reg == ST_EMIT)
        else $error("fixed processing order broken");

    a_mix_terms: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && state_reg == ST_MIX && chan_reg < TRIPLE_LO && term_reg == 2'h1 |=> state_reg == ST_EMIT)
        else $error("two-term mix did not emit");

    a_coef_gain_load: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && coef_valid && !coef_in.wide
        |=> coef_mem[$past(coef_in.addr)][COEF_W-1:0] == $past(coef_in.word[COEF_W-1:0]))
        else $error("gain word misplaced");

    a_coef_wide_pair: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && coef_valid && coef_in.wide && hi_valid_reg
        |=> coef_mem[$past(coef_in.addr)] == {$past(hi_reg), $past(coef_in.word)} && !hi_valid_reg)
        else $error("two-word coefficient misassembled");

    a_stall_hold: assert property (@(posedge ref_clk) disable iff (rst)
        out_valid_reg && !out_ready |=> out_valid_reg && out_reg == $past(out_reg))
        else $error("output changed while stalled");

    a_busy_refuse: assert property (@(posedge ref_clk) disable iff (rst)
        state_reg inside {ST_GAIN, ST_LEVEL, ST_MASTER, ST_EMIT, ST_MIX} |-> !in_ready_reg)
        else $error("input accepted while busy");

    a_wide_first: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && coef_valid && coef_in.wide && !hi_valid_reg
        |=> hi_valid_reg && hi_reg == $past(coef_in.word[HI_W-1:0]))
        else $error("first wide word not held");

    a_acc_restart: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && state_reg == ST_MIX && term_reg == term_last |=> acc_reg == ZERO_ACC && term_reg == 2'h0)
        else $error("mixer accumulator not cleared");

    a_mix_triple: assert property (@(posedge ref_clk) disable iff (rst)
        clk_en && state_reg == ST_MIX && chan_reg >= TRIPLE_LO && term_reg == 2'h1 |=> state_reg == ST_IDLE)
        else $error("three-term mix ended early");

endmodule

`default_nettype wire

// ### coef_host_model.sv
// Serial control host model: hands coefficient words to the datapath.
// Assumes the testbench calls its tasks right after a rising edge of ref_clk.
`timescale 1ns/100ps
`default_nettype none

module coef_host_model
    import audio_dp_pkg::*;
(
    // Clock
    input  wire logic          ref_clk,
    // Coefficient words
    output logic               coef_valid,
    output var coef_word_type  coef_in
);
    // ****************************************
    // Word transfers
    // ****************************************
    initial begin
        coef_valid = 1'b0;
        coef_in    = '0;
    end

    // One 32-bit word per strobe; released word is inverted, not held
    task automatic send_word(input logic wide, input logic [ADDR_W-1:0] addr, input logic [WORD_W-1:0] word);
        coef_valid <= 1'b1;
        coef_in    <= {wide, addr, word};
        @(posedge ref_clk);
        coef_valid <= 1'b0;
        coef_in    <= ~{wide, addr, word};
        // Let an edge pass so the next strobe is never set in the same step
        @(posedge ref_clk);
    endtask

    // Gain: 5.23 signed, low 28 bits, top nibble zero
    task automatic send_gain(input logic [ADDR_W-1:0] addr, input logic [COEF_W-1:0] g);
        send_word(1'b0, addr, {4'h0, g});
    endtask

    // Level: 25.23 signed, right-justified in two back-to-back words
    task automatic send_level(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] v);
        coef_valid <= 1'b1;
        coef_in    <= {1'b1, addr, {16'h0, v[47:32]}};
        @(posedge ref_clk);
        send_word(1'b1, addr, v[31:0]);
    endtask
endmodule

`default_nettype wire

// ### audio_fixed_point_datapath_tb_top.sv
// Self-checking testbench of the fixed-point audio datapath.
// Assumes coef_host_model as the coefficient source and default store values.
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; $display("BAD %0t got %h exp %h", $time, g, e); end end

module audio_fixed_point_datapath_tb_top;
    import audio_dp_pkg::*;

    // ****************************************
    // Signals and mirrors
    // ****************************************
    logic           ref_clk;
    logic           rst;
    logic           clk_en;
    logic           high_rate;
    logic           in_valid;
    sample_in_type  in_sample;
    logic           in_ready;
    logic           out_valid;
    sample_out_type out_sample;
    logic           out_ready;
    logic           coef_valid;
    coef_word_type  coef_in;
    logic           coef_pending;
    int             num_errors   = 0;
    int             total_checks = 0;
    logic [27:0]    gm [8]       = '{default: 28'h0800000};
    logic [47:0]    lm [8]       = '{default: 48'h0};
    logic [27:0]    mm           = 28'h0800000;

    always #4 ref_clk = ~ref_clk;

    audio_fixed_point_datapath DUT (
        .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .high_rate(high_rate),
        .in_valid(in_valid), .in_sample(in_sample), .in_ready(in_ready),
        .out_valid(out_valid), .out_sample(out_sample), .out_ready(out_ready),
        .coef_valid(coef_valid), .coef_in(coef_in), .coef_pending(coef_pending));

    coef_host_model host (.ref_clk(ref_clk), .coef_valid(coef_valid), .coef_in(coef_in));

    // ****************************************
    // Reference arithmetic
    // ****************************************
    function automatic logic [47:0] mt(input logic [47:0] s, input logic [27:0] g);
        logic signed [75:0] p;
        p = $signed(s) * $signed(g);
        return p[70:23];
    endfunction

    function automatic logic [47:0] sadd(input logic [47:0] a, input logic [47:0] b);
        logic [48:0] t;
        t = {a[47], a} + {b[47], b};
        if (t[48:47] == 2'b01) return SAT_MAX;
        if (t[48:47] == 2'b10) return SAT_MIN;
        return t[47:0];
    endfunction

    function automatic logic [47:0] exp_out(input logic [2:0] ch, input logic [47:0] x);
        if (high_rate && ch >= 3'h2 && ch <= 3'h6) return mt(x, mm);
        return mt(sadd(mt(x, gm[ch]), lm[ch]), mm);
    endfunction

    // ****************************************
    // Stream and coefficient tasks
    // ****************************************
    task automatic put(input logic mx, input logic [2:0] ch, input logic [47:0] d);
        int n;
        n = 0;
        in_valid  <= 1'b1;
        in_sample <= {mx, ch, d};
        do begin @(posedge ref_clk); n++; end while (in_ready !== 1'b1 && n < 200);
        `CHK(in_ready, 1'b1)
        in_valid  <= 1'b0;
        in_sample <= ~{mx, ch, d};
        @(posedge ref_clk);
    endtask

    task automatic get(input logic [2:0] ch, input logic [47:0] d);
        int n;
        n = 0;
        out_ready <= 1'b1;
        do begin @(posedge ref_clk); n++; end while (out_valid !== 1'b1 && n < 200);
        `CHK(out_valid, 1'b1)
        `CHK(out_sample.chan, ch)
        `CHK(out_sample.data, d)
        out_ready <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wg(input logic [4:0] a, input logic [27:0] g);
        if (a < 5'h8) gm[a[2:0]] = g;
        if (a == MASTER_ADDR) mm = g;
        host.send_gain(a, g);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        `CHK(in_ready, 1'b1)
        `CHK(out_valid, 1'b0)
        `CHK(coef_pending, 1'b0)
        `CHK(out_sample, '0)
        put(1'b0, 3'h3, 48'hf123_4567_89ab);
        clk_en <= 1'b0;
        repeat (10) @(posedge ref_clk);
        `CHK(out_valid, 1'b0)
        clk_en <= 1'b1;
        get(3'h3, 48'hf123_4567_89ab);
    endtask

    task automatic t_gain;
        wg(5'h1, 28'hfc00000);
        put(1'b0, 3'h1, 48'h0000_0123_4567);
        get(3'h1, exp_out(3'h1, 48'h0000_0123_4567));
        wg(5'h5, 28'h7800000);
        put(1'b0, 3'h5, 48'h1000_0000_0001);
        get(3'h5, exp_out(3'h5, 48'h1000_0000_0001));
    endtask

    task automatic t_level;
        lm[2] = 48'h0001_0000_0000;
        host.send_level(LEVEL_BASE + 5'h2, lm[2]);
        put(1'b0, 3'h2, 48'h7fff_0000_0000);
        get(3'h2, SAT_MAX);
        lm[4] = 48'hffff_e000_0000;
        host.send_word(1'b1, LEVEL_BASE + 5'h4, {16'h0, lm[4][47:32]});
        @(posedge ref_clk);
        `CHK(coef_pending, 1'b1)
        host.send_word(1'b1, LEVEL_BASE + 5'h4, lm[4][31:0]);
        @(posedge ref_clk);
        `CHK(coef_pending, 1'b0)
        put(1'b0, 3'h4, 48'h8000_1000_0000);
        get(3'h4, SAT_MIN);
        put(1'b0, 3'h4, 48'h0000_3000_0000);
        get(3'h4, 48'h0000_1000_0000);
    endtask

    task automatic t_stall;
        put(1'b0, 3'h0, 48'h0000_0000_1234);
        put(1'b0, 3'h7, 48'hffff_ffff_0000);
        repeat (8) @(posedge ref_clk);
        `CHK(out_valid, 1'b1)
        `CHK(out_sample.data, 48'h0000_0000_1234)
        get(3'h0, 48'h0000_0000_1234);
        get(3'h7, 48'hffff_ffff_0000);
    endtask

    task automatic t_rate;
        for (int a = 0; a < 8; a++) wg(5'(a), 28'h0400000);
        wg(MASTER_ADDR, 28'h1000000);
        high_rate <= 1'b1;
        @(posedge ref_clk);
        for (int c = 0; c < 8; c++) begin
            put(1'b0, 3'(c), 48'h0000_0123_4000);
            get(3'(c), exp_out(3'(c), 48'h0000_0123_4000));
        end
        high_rate <= 1'b0;
        wg(MASTER_ADDR, 28'h0800000);
    endtask

    task automatic t_mix;
        wg(MIX_BASE, 28'h0400000);
        wg(MIX_BASE + 5'h1, 28'h0400000);
        put(1'b1, 3'h0, 48'h1);
        put(1'b1, 3'h0, 48'h1);
        get(3'h0, 48'h1);
        wg(MIX_BASE, 28'h0800000);
        wg(MIX_BASE + 5'h1, 28'h0800000);
        wg(MIX_BASE + 5'h2, 28'hf800000);
        put(1'b1, 3'h6, 48'h6000_0000_0000);
        put(1'b1, 3'h6, 48'h6000_0000_0000);
        put(1'b1, 3'h6, 48'h6000_0000_0000);
        get(3'h6, 48'h6000_0000_0000);
    endtask

    // ****************************************
    // Verdict, watchdog and main sequence
    // ****************************************
    task automatic report_and_stop;
        if (num_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        ref_clk   = 1'b0;
        rst       = 1'b1;
        clk_en    = 1'b1;
        high_rate = 1'b0;
        in_valid  = 1'b0;
        in_sample = '0;
        out_ready = 1'b0;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_reset();
        t_gain();
        t_level();
        t_stall();
        t_rate();
        t_mix();
        report_and_stop();
    end
endmodule

`default_nettype wire
